// ===== dv/fupc_array_model.sv
// Behavioural flash array that stands behind the program controller.
// Assumes the bench ties its read address to the table access address.
`timescale 1ns/1ps
module fupc_array_model (
  input  wire logic                    aclk,
  input  wire logic [15:0]             rd_addr,
  input  wire fupc_pkg::fupc_arr_cmd_s cmd,
  output logic [7:0]                   rdata
);
  import fupc_pkg::*;

  logic [7:0] mem [0:65535];

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end

  assign rdata = mem[rd_addr];

  // ****************************************************************
  // Array commands
  // ****************************************************************
  // Programming can only clear bits, so an unerased byte keeps stale zeros.
  always @(posedge aclk) begin
    if (cmd.erase) begin
      for (int i = 0; i < 128; i++) mem[{cmd.addr[15:7], 7'(i)}] = 8'hFF;
    end
    if (cmd.prog) begin
      mem[cmd.addr] = mem[cmd.addr] & cmd.wdata;
    end
  end
endmodule // fupc_array_model

// ===== dv/test_flash_user_program_control.sv
// Self-checking bench of the flash user program controller.
// Assumes fupc_top and the array model; erase length is shortened by parameter.
`timescale 1ns/1ps
module test_flash_user_program_control;
  import fupc_pkg::*;

  localparam int EC = 20;

  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, tbl_ack, irq_pending, tool_mode, erase_ok, busy;
  logic [3:0]    awaddr, araddr, wstrb;
  logic [31:0]   wdata, rdata, d;
  logic [1:0]    bresp, rresp, r;
  logic [7:0]    tbl_rdata, option_byte, arr_rdata, rd, v;
  logic [15:0]   reset_vector, e;
  fupc_tbl_req_s tbl_req;
  fupc_arr_cmd_s arr_cmd;
  int            errors, num_checks, bcnt;
  int            btot = 0;

  fupc_top #(.ERASE_CYCLES(EC)) u_fupc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .tbl_req(tbl_req),
    .tbl_rdata(tbl_rdata), .tbl_ack(tbl_ack), .irq_pending(irq_pending), .tool_mode(tool_mode),
    .option_byte(option_byte), .array_rdata(arr_rdata), .array_erase_ok(erase_ok), .array_cmd(arr_cmd),
    .busy(busy), .reset_vector(reset_vector));

  fupc_array_model u_fupc_array_model (.aclk(aclk), .rd_addr(tbl_req.addr), .cmd(arr_cmd), .rdata(arr_rdata));

  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  always @(posedge aclk) begin
    if (busy === 1'b1) btot <= btot + 1;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    int n;
    bit aw, w;
    n = 0;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      tick(n);
      if (awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) tick(n);
    r = bresp;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) tick(n);
    d = rdata;
    r = rresp;
  endtask

  task automatic tbl(input logic w, input logic [15:0] a, input logic [7:0] dv);
    tbl_req <= '{1'b1, w, a, dv};
    @(posedge aclk);
    tbl_req.req <= 1'b0;
    @(posedge aclk);
    chk("tbl_ack", 16'h0001, {15'h0000, tbl_ack});
    rd = tbl_rdata;
  endtask

  task automatic setup(input logic [7:0] key, input logic [15:0] sec);
    wr(FUPC_ADDR_KEY, key);
    wr(FUPC_ADDR_SEC_HI, sec[15:8]);
    wr(FUPC_ADDR_SEC_LO, sec[7:0]);
  endtask

  // Starts an operation and returns once busy has fallen, or early when it never rose.
  task automatic run_op(input logic [7:0] ctl, input int irq_at);
    int base;
    base = btot;
    wr(FUPC_ADDR_CTRL, ctl);
    for (int i = 0; i < 1000; i++) begin
      @(posedge aclk);
      bcnt = btot - base;
      if (!busy && (bcnt > 0 || i > 4)) break;
      if (irq_at > 0 && bcnt == irq_at) irq_pending <= 1'b1;
    end
    irq_pending <= 1'b0;
    if (busy !== 1'b0) begin
      errors++;
      print_verdict();
    end
  endtask

  function automatic logic [15:0] vec(input logic [7:0] ob);
    logic [15:0] t [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
    return (ob[7] || ob[2]) ? 16'h0100 : t[ob[6:5]];
  endfunction

  function automatic logic [15:0] prot_end(input logic [1:0] s);
    logic [15:0] t [4] = '{16'h01FF, 16'h02FF, 16'h04FF, 16'h08FF};
    return t[s];
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_pending, tool_mode} = '0;
    {awaddr, araddr, wdata, tbl_req, bcnt, errors, num_checks} = '0;
    wstrb = 4'hF;
    erase_ok = 1'b1;
    option_byte = 8'h04;
    void'($urandom(91));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(FUPC_ADDR_KEY);
    chk("key_reset", 16'h0000, d[15:0]);
    v = $urandom;
    wr(FUPC_ADDR_SEC_HI, v);
    rd_reg(FUPC_ADDR_SEC_HI);
    chk("sec_hi", {8'h00, v}, d[15:0]);
    v = $urandom;
    wr(FUPC_ADDR_SEC_LO, v);
    rd_reg(FUPC_ADDR_SEC_LO);
    chk("sec_lo", {8'h00, v & 8'h80}, d[15:0]);
    rd_reg(4'h2);
    chk("unmapped", {14'h0000, FUPC_RESP_SLVERR}, {14'h0000, r});
    wr(4'h6, FUPC_KEY_ENABLE);
    chk("wr_unaligned", {14'h0000, FUPC_RESP_SLVERR}, {14'h0000, r});
    rd_reg(FUPC_ADDR_KEY);
    chk("key_kept", 16'h0000, d[15:0]);
    v = $urandom;
    if (v == FUPC_KEY_ENABLE) v = 8'h5A;
    setup(v, 16'h1000);
    run_op(8'hA1, 0);
    chk("bad_key_busy", 16'h0000, 16'(bcnt));
    setup(FUPC_KEY_ENABLE, 16'h1000);
    wr(FUPC_ADDR_CTRL, 8'h50);
    v = $urandom;
    tbl(1'b1, 16'h1004, v);
    tbl(1'b0, 16'h1004, 8'h00);
    chk("prog", {8'h00, v}, {8'h00, rd});
    tbl(1'b1, 16'h1084, 8'h00);
    tbl(1'b0, 16'h1084, 8'h00);
    chk("out_of_sector", 16'h00FF, {8'h00, rd});
    wr(FUPC_ADDR_KEY, 8'h00);
    tbl(1'b1, 16'h1008, 8'h00);
    tbl(1'b0, 16'h1008, 8'h00);
    chk("prog_no_key", 16'h00FF, {8'h00, rd});
    // Good erase, aborted erase, good erase, failed erase.
    setup(FUPC_KEY_ENABLE, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      erase_ok <= (i != 3);
      run_op(8'hA1, (i == 1) ? 5 : 0);
      chk("erase_len", 16'h0001, (i == 1) ? 16'(bcnt >= 5 && bcnt <= 8) : 16'(bcnt >= EC && bcnt <= EC + 1));
      rd_reg(FUPC_ADDR_CTRL);
      chk("erase_fail", 16'(i % 2), {15'h0000, d[FUPC_BIT_FAIL]});
    end
    tbl(1'b0, 16'h1004, 8'h00);
    chk("erased", 16'h00FF, {8'h00, rd});
    erase_ok <= 1'b1;
    tool_mode <= 1'b1;
    run_op(8'hA1, 0);
    chk("tool_mode_busy", 16'h0000, 16'(bcnt));
    tool_mode <= 1'b0;
    for (int c = 0; c < 16; c++) begin
      option_byte <= {3'(c), 2'($urandom), c[3], 2'($urandom)};
      repeat (2) @(posedge aclk);
      chk("vector", vec(option_byte), reset_vector);
    end
    for (int s = 0; s < 4; s++) begin
      option_byte <= {3'($urandom), 3'b000, 2'(s)};
      e = prot_end(2'(s));
      setup(FUPC_KEY_ENABLE, e - 16'h007F);
      run_op(8'hA1, 0);
      chk("protected", 16'h0000, 16'(bcnt));
      setup(FUPC_KEY_ENABLE, e + 16'h0001);
      run_op(8'hA1, 0);
      chk("unprotected", 16'h0001, 16'(bcnt > 0));
    end
    option_byte <= 8'h04;
    setup(FUPC_KEY_ENABLE, 16'h0100);
    run_op(8'hA1, 0);
    chk("boot_disabled", 16'h0001, 16'(bcnt > 0));
    run_op(8'h61, 0);
    chk("lock_len", 16'h0001, 16'(bcnt >= FUPC_LOCK_CYCLES && bcnt <= FUPC_LOCK_CYCLES + 1));
    rd_reg(FUPC_ADDR_CTRL);
    chk("locked", 16'h0001, {15'h0000, d[FUPC_BIT_LOCKED]});
    run_op(8'hA1, 0);
    chk("locked_erase", 16'h0000, 16'(bcnt));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(FUPC_ADDR_KEY);
    chk("key_reset_again", 16'h0000, d[15:0]);
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    print_verdict();
  end
endmodule // test_flash_user_program_control

// ===== src/fupc_pkg.sv
// Constants, register map and carrier types of the flash user program controller.
// Assumes a 20 MHz aclk and an AXI4-Lite master in the CPU subsystem.
//
// Overview of operation
// RULE_01 - Control bit 0 starts erase or hard lock.
// RULE_02 - CPU waits for completion before sector access.
// RULE_03 - Table reads and writes ignore the start bit.
// RULE_04 - Interrupt request aborts a running erase.
// RULE_05 - Erase result flag: zero ok, one failed.
// RULE_06 - Reset clears the programming key register.
// RULE_07 - Only key A5h enables erase, program, lock.
// RULE_08 - Two sector address registers, high and low.
// RULE_09 - 512 sectors of 128 bytes; low bits ignored.
// RULE_10 - CPU reloads sector registers per target sector.
// RULE_11 - Programming only into an erased sector; the controller does not check whether the sector is erased.
// RULE_12 - Erase lasts at least ten milliseconds.
// RULE_13 - Erase offered only in user program mode.
// RULE_14 - User mode: erase, program, read, hard lock.
// RULE_15 - Enabled boot-loader sectors refuse erase and program.
// RULE_16 - Disable bit makes boot area normal memory.
// RULE_17 - Option bits 2..0 set protected size.
// RULE_18 - Option bits 7..5 set reset vector.
// RULE_19 - Vector choice needs enable and selection zero.
// RULE_20 - Vector and size fields decode independently.
// RULE_21 - Software guards against stray control writes.
// RULE_22 - Control value A1h starts sector erase.
// RULE_23 - Control value 50h selects byte program mode.
// RULE_24 - Upper nibble 0110 plus start sets hard lock.
// RULE_25 - Out-of-sector or disabled program writes ignored.
// RULE_26 - Busy shown from start until completion.
package fupc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] FUPC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] FUPC_ADDR_KEY    = 4'h4;
  localparam logic [3:0] FUPC_ADDR_SEC_HI = 4'h8;
  localparam logic [3:0] FUPC_ADDR_SEC_LO = 4'hC;

  localparam logic [7:0] FUPC_KEY_ENABLE  = 8'hA5;
  localparam logic [7:0] FUPC_KEY_RESET   = 8'h00;
  localparam logic [3:0] FUPC_MODE_ERASE  = 4'hA;
  localparam logic [3:0] FUPC_MODE_PROG   = 4'h5;
  localparam logic [3:0] FUPC_MODE_LOCK   = 4'h6;
  localparam int         FUPC_BIT_START   = 0;
  localparam int         FUPC_BIT_BUSY    = 1;
  localparam int         FUPC_BIT_LOCKED  = 2;
  localparam int         FUPC_BIT_FAIL    = 3;
  localparam logic [7:0] FUPC_SEC_LO_MASK = 8'h80;
  localparam logic [1:0] FUPC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] FUPC_RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Option byte fields and boot area
  // ****************************************************************
  localparam int          FUPC_OPT_NOBOOT  = 2;
  localparam int          FUPC_OPT_VECSEL  = 7;
  localparam logic [15:0] FUPC_BOOT_BASE   = 16'h0100;
  localparam logic [15:0] FUPC_VEC_DEFAULT = 16'h0100;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint FUPC_CLK_HZ        = 20000000;
  localparam longint FUPC_ERASE_MS      = 10;
  localparam int     FUPC_ERASE_CYCLES  = int'((FUPC_ERASE_MS * FUPC_CLK_HZ + 999) / 1000);
  localparam int     FUPC_LOCK_CYCLES   = 4;

  typedef enum logic [1:0] {
    FUPC_IDLE  = 2'b00,
    FUPC_ERASE = 2'b01,
    FUPC_LOCK  = 2'b10
  } fupc_state_e;

  // Table-access bus from the CPU core.
  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fupc_tbl_req_s;

  // Command to the flash array.
  typedef struct packed {
    logic        erase;
    logic        prog;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fupc_arr_cmd_s;

endpackage

// ===== src/fupc_top.sv
// Flash user program controller: key, control and sector registers on AXI4-Lite,
// sector erase sequencing, byte program gating, hard lock and boot area guard.
// Assumes a flash array that performs commands and returns read data and an erase
// verify result; the CPU supplies table accesses and the interrupt request line.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fupc_top #(
  parameter int ERASE_CYCLES = fupc_pkg::FUPC_ERASE_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [3:0]              s_axil_awaddr,
  input  wire logic                    s_axil_awvalid,
  output logic                         s_axil_awready,
  input  wire logic [31:0]             s_axil_wdata,
  input  wire logic [3:0]              s_axil_wstrb,
  input  wire logic                    s_axil_wvalid,
  output logic                         s_axil_wready,
  output logic [1:0]                   s_axil_bresp,
  output logic                         s_axil_bvalid,
  input  wire logic                    s_axil_bready,
  input  wire logic [3:0]              s_axil_araddr,
  input  wire logic                    s_axil_arvalid,
  output logic                         s_axil_arready,
  output logic [31:0]                  s_axil_rdata,
  output logic [1:0]                   s_axil_rresp,
  output logic                         s_axil_rvalid,
  input  wire logic                    s_axil_rready,
  input  wire fupc_pkg::fupc_tbl_req_s tbl_req,
  output logic [7:0]                   tbl_rdata,
  output logic                         tbl_ack,
  input  wire logic                    irq_pending,
  input  wire logic                    tool_mode,
  input  wire logic [7:0]              option_byte,
  input  wire logic [7:0]              array_rdata,
  input  wire logic                    array_erase_ok,
  output fupc_pkg::fupc_arr_cmd_s      array_cmd,
  output logic                         busy,
  output logic [15:0]                  reset_vector
);
  import fupc_pkg::*;

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [7:0]  key;
  logic [3:0]  mode;
  logic        fail;
  logic        locked;
  logic [7:0]  sec_hi;
  logic [7:0]  sec_lo;
  fupc_state_e state;
  logic [31:0] count;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;

  logic        unlocked;
  logic        do_write;
  logic        start_erase;
  logic        start_lock;
  logic [15:0] boot_end;
  logic        prog_ok;
  logic        sector_blocked;
  logic [15:0] sector_base;
  logic [7:0]  ctrl_view;

  // Protected area end for a size code; shared by size decode and vector decode.
  function automatic logic [15:0] boot_last(input logic [1:0] code);
    unique case (code)
      2'b00: boot_last = 16'h01FF;
      2'b01: boot_last = 16'h02FF;
      2'b10: boot_last = 16'h04FF;
      2'b11: boot_last = 16'h08FF;
    endcase
  endfunction

  // True when an address lies in the protected boot area.
  function automatic logic in_boot(input logic [15:0] a, input logic [15:0] last);
    in_boot = (a >= FUPC_BOOT_BASE) && (a <= last);
  endfunction

  assign unlocked    = (key == FUPC_KEY_ENABLE) && !tool_mode && !locked;         // RULE_07 RULE_13
  assign sector_base = {sec_hi, sec_lo & FUPC_SEC_LO_MASK};                       // RULE_08 RULE_09
  assign boot_end    = boot_last(option_byte[1:0]);                               // RULE_17 RULE_20
  assign sector_blocked = !option_byte[FUPC_OPT_NOBOOT] &&
                          (in_boot(sector_base, boot_end) ||
                           in_boot(sector_base + 16'h007F, boot_end));            // RULE_15 RULE_16
  assign ctrl_view   = {mode, fail, locked, (state != FUPC_IDLE), 1'b0};
  assign do_write    = aw_held && w_held && !s_axil_bvalid;
  assign start_erase = do_write && (aw_addr == FUPC_ADDR_CTRL) && w_lane0 && unlocked &&
                       (state == FUPC_IDLE) && (w_data[7:4] == FUPC_MODE_ERASE) &&
                       w_data[FUPC_BIT_START] && !sector_blocked;                  // RULE_01 RULE_22
  assign start_lock  = do_write && (aw_addr == FUPC_ADDR_CTRL) && w_lane0 && unlocked &&
                       (state == FUPC_IDLE) && (w_data[7:4] == FUPC_MODE_LOCK) &&
                       w_data[FUPC_BIT_START];                                     // RULE_24
  assign prog_ok     = unlocked && (mode == FUPC_MODE_PROG) && (state == FUPC_IDLE) &&
                       (tbl_req.addr[15:7] == sector_base[15:7]) && !sector_blocked; // RULE_23 RULE_25 RULE_11

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 4'h0;
      w_data         <= 8'h00;
      w_lane0        <= 1'b0;
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= FUPC_RESP_OKAY;
    end else begin
      s_axil_awready <= !aw_held && !s_axil_awready && !s_axil_bvalid;
      s_axil_wready  <= !w_held && !s_axil_wready && !s_axil_bvalid;
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axil_wdata[7:0];
        w_lane0 <= s_axil_wstrb[0];
      end
      if (do_write) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (aw_addr[1:0] == 2'b00) ? FUPC_RESP_OKAY : FUPC_RESP_SLVERR;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Key and sector registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key    <= FUPC_KEY_RESET;                                                   // RULE_06
      sec_hi <= 8'h00;
      sec_lo <= 8'h00;
    end else if (do_write && w_lane0) begin
      if (aw_addr == FUPC_ADDR_KEY) begin
        key <= w_data;
      end
      if (aw_addr == FUPC_ADDR_SEC_HI) begin
        sec_hi <= w_data;                                                         // RULE_08
      end
      if (aw_addr == FUPC_ADDR_SEC_LO) begin
        sec_lo <= w_data & FUPC_SEC_LO_MASK;                                      // RULE_09
      end
    end
  end

  // Mode nibble is software visible; it is only written while unlocked.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= 4'h0;
    end else if (do_write && w_lane0 && (aw_addr == FUPC_ADDR_CTRL) && unlocked && (state == FUPC_IDLE)) begin
      mode <= w_data[7:4];                                                        // RULE_14
    end
  end

  // ****************************************************************
  // Erase and hard lock sequencer
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state  <= FUPC_IDLE;
      count  <= 32'h0000_0000;
      fail   <= 1'b0;
      locked <= 1'b0;
      busy   <= 1'b0;
    end else begin
      unique case (state)
        FUPC_IDLE: begin
          count <= 32'h0000_0000;
          if (start_erase) begin
            state <= FUPC_ERASE;
            busy  <= 1'b1;                                                        // RULE_26
          end else if (start_lock) begin
            state <= FUPC_LOCK;
            busy  <= 1'b1;                                                        // RULE_26
          end
        end
        FUPC_ERASE: begin
          count <= count + 32'h0000_0001;
          if (irq_pending) begin
            state <= FUPC_IDLE;                                                   // RULE_04
            busy  <= 1'b0;
            fail  <= 1'b1;                                                        // RULE_05
          end else if (count == 32'(ERASE_CYCLES - 1)) begin
            state <= FUPC_IDLE;                                                   // RULE_12
            busy  <= 1'b0;
            fail  <= !array_erase_ok;                                             // RULE_05
          end
        end
        FUPC_LOCK: begin
          count <= count + 32'h0000_0001;
          if (count == 32'(FUPC_LOCK_CYCLES - 1)) begin
            state  <= FUPC_IDLE;
            busy   <= 1'b0;
            locked <= 1'b1;                                                       // RULE_24
          end
        end
        default: begin
          state <= FUPC_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flash array commands and table access
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      array_cmd <= '0;
      tbl_rdata <= 8'h00;
      tbl_ack   <= 1'b0;
    end else begin
      array_cmd.erase <= start_erase;
      array_cmd.prog  <= tbl_req.req && tbl_req.write && prog_ok;                 // RULE_03 RULE_25
      array_cmd.read  <= tbl_req.req && !tbl_req.write;                           // RULE_03
      array_cmd.addr  <= start_erase ? sector_base : tbl_req.addr;
      array_cmd.wdata <= tbl_req.wdata;
      tbl_ack         <= tbl_req.req;
      tbl_rdata       <= array_rdata;
    end
  end

  // Reset vector is taken from the option byte after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector <= FUPC_VEC_DEFAULT;
    end else if (option_byte[FUPC_OPT_NOBOOT] || option_byte[FUPC_OPT_VECSEL]) begin
      reset_vector <= FUPC_VEC_DEFAULT;                                           // RULE_19
    end else begin
      reset_vector <= boot_last(option_byte[6:5]) + 16'h0001;                     // RULE_18 RULE_20
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= FUPC_RESP_OKAY;
    end else begin
      s_axil_arready <= !s_axil_rvalid && !s_axil_arready;
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= FUPC_RESP_OKAY;
        unique case (s_axil_araddr)
          FUPC_ADDR_CTRL:   s_axil_rdata <= {24'h00_0000, ctrl_view};
          FUPC_ADDR_KEY:    s_axil_rdata <= {24'h00_0000, key};
          FUPC_ADDR_SEC_HI: s_axil_rdata <= {24'h00_0000, sec_hi};
          FUPC_ADDR_SEC_LO: s_axil_rdata <= {24'h00_0000, sec_lo};
          default: begin
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= FUPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_KEY_RESET: assert property (@(posedge aclk) !aresetn |=> key == FUPC_KEY_RESET) // RULE_06
    else $error("key not cleared by reset");
  AST_KEY_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_07
    $rose(busy) |-> $past(key) == FUPC_KEY_ENABLE)
    else $error("operation started without key");
  AST_START_BUSY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
    start_erase |=> busy && state == FUPC_ERASE)
    else $error("erase start not taken");
  AST_ERASE_MIN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
    $fell(busy) && $past(state) == FUPC_ERASE |-> $past(irq_pending) || $past(count) == 32'(ERASE_CYCLES - 1))
    else $error("erase ended early");
  AST_IRQ_ABORT: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    (state == FUPC_ERASE) && irq_pending |=> state == FUPC_IDLE && fail && !busy)
    else $error("interrupt did not abort erase");
  AST_PROG_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_25
    tbl_req.req && tbl_req.write && (tbl_req.addr[15:7] != sector_base[15:7]) |=> !array_cmd.prog)
    else $error("out of sector program passed");
  AST_BOOT_GUARD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_15
    (array_cmd.erase || array_cmd.prog) && !option_byte[FUPC_OPT_NOBOOT] |->
      (array_cmd.addr > boot_end) || ((array_cmd.addr | 16'h007F) < FUPC_BOOT_BASE))
    else $error("boot area not protected");
  AST_LOCK_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_24
    locked |=> locked && !array_cmd.prog)
    else $error("hard lock released");
  AST_READ_FREE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    tbl_req.req && !tbl_req.write |=> array_cmd.read)
    else $error("table read not served");
  AST_TOOL_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
    $rose(busy) |-> !$past(tool_mode))
    else $error("operation started in tool mode");
  AST_ERASE_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    array_cmd.erase |-> array_cmd.addr[6:0] == 7'h00)
    else $error("erase address not on a sector base");
  AST_BUSY_STATE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_26
    busy == (state != FUPC_IDLE))
    else $error("busy does not follow the sequencer");
  AST_FAIL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    $changed(fail) |-> $past(state) == FUPC_ERASE)
    else $error("erase result changed outside an erase");

  COV_ERASE_OK: cover property (@(posedge aclk) disable iff (!aresetn) $fell(busy) && !fail);
  COV_ERASE_ABORT: cover property (@(posedge aclk) disable iff (!aresetn) (state == FUPC_ERASE) && irq_pending);
  COV_PROG: cover property (@(posedge aclk) disable iff (!aresetn) array_cmd.prog);
  COV_LOCK: cover property (@(posedge aclk) disable iff (!aresetn) $rose(locked));

endmodule // fupc_top
